/* File: hw/sync_burst_sram_port.sv */
// Core of a synchronous burst SRAM: command decode, late-write pipeline,
// read pipeline in pipeline or flow-through mode, and flip-flop storage.
// Assumes the controller runs on clk; output enable, sleep and burst order
// arrive asynchronously and are resynchronised here.

// Summary of operation
// - Clock gate high freezes all state but the pin synchronisers and bus drive.
// - Sample inputs on edges; three pins async.
// - Selected only when both selects low, middle high.
// - Read starts with gate, selects, store high, load.
// - Pipeline read data leaves output register next edge.
// - Write taken when selected, gated, store low.
// - Each byte enable writes only its lane.
// - All byte enables high is a no-op.
// - Pipeline write data taken at third edge.
// - Flow-through read data follows address edge.
// - Flow-through write data taken at second edge.
// - Write latency equals read latency per mode.
// - Low address bits preset burst counter.
// - Mode strap low selects flow-through.
// - Order strap low selects linear burst.
// - Sleep input stops driving the data bus.
// - Output enable high stops driving the bus.
// - Advance steps counter and uses its address.
// - Counter wraps after four addresses.
// - Linear adds count, interleaved XORs count.
module sync_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = sram_port_pkg::ADDR_W,
    parameter int LANES = sram_port_pkg::LANES,
    parameter int LANE_W = sram_port_pkg::LANE_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkGateN,
    input wire logic selectOneN,
    input wire logic selectTwo,
    input wire logic selectThreeN,
    input wire logic storeRequestN,
    input wire logic [LANES-1:0] byteLaneWriteN,
    input wire logic burstStepLoad,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES*LANE_W-1:0] dataLaneIn,
    output logic [LANES*LANE_W-1:0] dataLaneOut,
    output logic dataLaneOe,
    input wire logic outputDriveN,
    input wire logic sleepRequest,
    input wire logic flowThroughSelN,
    input wire logic linearOrderSelN
);
    import sram_port_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;
    localparam int DW = LANES * LANE_W;

    logic [DW-1:0] mem [DEPTH];

    logic driveMeta, driveSync;
    logic sleepMeta, sleepSync;
    logic orderMeta, orderSync;

    logic enabled, selected, flowMode, loadBurst, stepBurst;
    op_t cmdOp, lastOp;
    logic [BURST_W-1:0] curLsbs;
    logic [ADDR_W-BURST_W-1:0] baseHigh;
    logic [ADDR_W-1:0] curAddr;

    logic wr1Valid, wr2Valid;
    logic [ADDR_W-1:0] wr1Addr, wr2Addr;
    logic [LANES-1:0] wr1ByteN, wr2ByteN;
    logic commitValid;
    logic [ADDR_W-1:0] commitAddr;
    logic [LANES-1:0] commitByteN;

    logic rd1Valid;
    logic [ADDR_W-1:0] rd1Addr;
    logic readShown, next_readShown;

    // Output enable, sleep and order are asynchronous pins: two flops each
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            driveMeta <= SYNC_RESET_HIGH;
            driveSync <= SYNC_RESET_HIGH;
            sleepMeta <= SYNC_RESET_LOW;
            sleepSync <= SYNC_RESET_LOW;
            orderMeta <= SYNC_RESET_LOW;
            orderSync <= SYNC_RESET_LOW;
        end else begin
            driveMeta <= outputDriveN;
            driveSync <= driveMeta;
            sleepMeta <= sleepRequest;
            sleepSync <= sleepMeta;
            orderMeta <= linearOrderSelN;
            orderSync <= orderMeta;
        end
    end

    // Sleep also blocks commands so no hidden state moves while asleep
    assign enabled = !clkGateN && !sleepSync;
    assign selected = !selectOneN && selectTwo && !selectThreeN;
    assign flowMode = !flowThroughSelN;

    always_comb begin
        if (burstStepLoad) begin
            cmdOp = lastOp;
        end else if (!selected) begin
            cmdOp = OP_IDLE;
        end else if (storeRequestN) begin
            cmdOp = OP_READ;
        end else begin
            cmdOp = OP_WRITE;
        end
    end

    assign loadBurst = enabled && !burstStepLoad && selected;
    assign stepBurst = enabled && burstStepLoad && (lastOp != OP_IDLE);

    burst_addr_gen u_burst (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(loadBurst),
        .advance(stepBurst),
        .startLsbs(addr[BURST_W-1:0]),
        .linearN(orderSync),
        .curLsbs(curLsbs)
    );

    assign curAddr = burstStepLoad ? {baseHigh, curLsbs} : addr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lastOp <= OP_IDLE;
            baseHigh <= '0;
        end else if (enabled && !burstStepLoad) begin
            lastOp <= cmdOp;
            if (selected) begin
                baseHigh <= addr[ADDR_W-1:BURST_W];
            end
        end
    end

    // Write command pipeline: two stages, the mode picks where data is taken
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr1Valid <= 1'b0;
            wr2Valid <= 1'b0;
            wr1Addr <= '0;
            wr2Addr <= '0;
            wr1ByteN <= '1;
            wr2ByteN <= '1;
        end else if (enabled) begin
            wr1Valid <= (cmdOp == OP_WRITE) && !(&byteLaneWriteN);
            wr1Addr <= curAddr;
            wr1ByteN <= byteLaneWriteN;
            wr2Valid <= wr1Valid;
            wr2Addr <= wr1Addr;
            wr2ByteN <= wr1ByteN;
        end
    end

    assign commitValid = enabled && (flowMode ? wr1Valid : wr2Valid);
    assign commitAddr = flowMode ? wr1Addr : wr2Addr;
    assign commitByteN = flowMode ? wr1ByteN : wr2ByteN;

    always_ff @(posedge clk) begin
        if (commitValid) begin
            for (int lane = 0; lane < LANES; lane++) begin
                if (!commitByteN[lane]) begin
                    mem[commitAddr][lane*LANE_W +: LANE_W] <=
                        dataLaneIn[lane*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Read pipeline; a stall keeps the last word on the bus
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd1Valid <= 1'b0;
            rd1Addr <= '0;
        end else if (enabled) begin
            rd1Valid <= (cmdOp == OP_READ);
            rd1Addr <= curAddr;
        end
    end

    always_comb begin
        if (!enabled) begin
            next_readShown = readShown;
        end else if (flowMode) begin
            next_readShown = (cmdOp == OP_READ);
        end else begin
            next_readShown = rd1Valid;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            readShown <= 1'b0;
            dataLaneOut <= '0;
        end else begin
            readShown <= next_readShown;
            if (enabled && flowMode && cmdOp == OP_READ) begin
                dataLaneOut <= mem[curAddr];
            end else if (enabled && !flowMode && rd1Valid) begin
                dataLaneOut <= mem[rd1Addr];
            end
        end
    end

    // Bus drive also checked against the pins every edge, even when stalled
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dataLaneOe <= OE_RESET;
        end else begin
            dataLaneOe <= next_readShown && !driveSync && !sleepSync;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    property p_stall_holds;
        clkGateN |=> $stable(wr1Valid) && $stable(rd1Valid) && $stable(lastOp);
    endproperty
    a_stall_holds: assert property (p_stall_holds)
        else $error("state moved while clock gate high");

    property p_deselect_no_read;
        enabled && !burstStepLoad && !selected |=> !rd1Valid && !wr1Valid;
    endproperty
    a_deselect_no_read: assert property (p_deselect_no_read)
        else $error("access started while deselected");

    property p_read_start;
        enabled && !burstStepLoad && selected && storeRequestN |=> rd1Valid;
    endproperty
    a_read_start: assert property (p_read_start)
        else $error("read not started");

    property p_pipe_latency;
        enabled && !flowMode && cmdOp == OP_READ ##1 enabled && !flowMode
            // Word as read at the data edge: a late write may land on that same edge
            |=> readShown && dataLaneOut == $past(mem[rd1Addr]);
    endproperty
    a_pipe_latency: assert property (p_pipe_latency)
        else $error("pipeline read data not presented after two edges");

    property p_flow_latency;
        enabled && flowMode && cmdOp == OP_READ |=> readShown;
    endproperty
    a_flow_latency: assert property (p_flow_latency)
        else $error("flow-through read not presented after one edge");

    property p_write_abort;
        enabled && cmdOp == OP_WRITE && (&byteLaneWriteN) |=> !wr1Valid;
    endproperty
    a_write_abort: assert property (p_write_abort)
        else $error("write with no byte enables was kept");

    property p_pipe_write_lane;
        commitValid && !flowMode && !commitByteN[0]
            |=> mem[$past(commitAddr)][LANE_W-1:0] == $past(dataLaneIn[LANE_W-1:0]);
    endproperty
    a_pipe_write_lane: assert property (p_pipe_write_lane)
        else $error("late write lane not stored");

    property p_flow_write_stage;
        enabled && flowMode && cmdOp == OP_WRITE && !(&byteLaneWriteN)
            ##1 enabled |-> commitValid && commitAddr == $past(curAddr);
    endproperty
    a_flow_write_stage: assert property (p_flow_write_stage)
        else $error("flow-through write not committed at second edge");

    property p_drive_off;
        driveSync || sleepSync |=> !dataLaneOe;
    endproperty
    a_drive_off: assert property (p_drive_off)
        else $error("bus driven while disabled or asleep");

    property p_burst_preset;
        loadBurst ##1 enabled && burstStepLoad && orderSync
            |-> curLsbs == ($past(addr[BURST_W-1:0]) ^ COUNT_STEP);
    endproperty
    a_burst_preset: assert property (p_burst_preset)
        else $error("burst counter not preset from low address bits");

    property p_linear_step;
        loadBurst ##1 enabled && burstStepLoad && !orderSync
            |-> curLsbs == BURST_W'($past(addr[BURST_W-1:0]) + COUNT_STEP);
    endproperty
    a_linear_step: assert property (p_linear_step)
        else $error("linear burst did not count up from the start bits");

    property p_burst_wrap;
        loadBurst ##1 stepBurst [*4] |-> curLsbs == $past(addr[BURST_W-1:0], 4);
    endproperty
    a_burst_wrap: assert property (p_burst_wrap)
        else $error("burst counter did not wrap after four addresses");

    c_pipe_read: cover property (enabled && !flowMode && cmdOp == OP_READ ##2 dataLaneOe);
    c_flow_write: cover property (commitValid && flowMode);
    c_burst_four: cover property (loadBurst ##1 stepBurst [*3]);
    c_stall_read: cover property (readShown && clkGateN ##1 clkGateN);
endmodule

/* File: hw/sram_port_pkg.sv */
// Shared constants and types for the synchronous burst SRAM port.
// Assumes a single clock domain and a synchronous, active-high reset.
package sram_port_pkg;
    localparam int LANES = 8;
    localparam int LANE_W = 9;
    localparam int DATA_W = 72;
    localparam int ADDR_W = 19;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic [1:0] COUNT_STEP = 2'h1;
    localparam logic SYNC_RESET_HIGH = 1'b1;
    localparam logic SYNC_RESET_LOW = 1'b0;
    localparam logic OE_RESET = 1'b0;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10
    } op_t;
endpackage

/* File: hw/burst_addr_gen.sv */
// Two-bit burst address generator with linear or interleaved order.
// Assumes load and advance are already qualified by the clock gate.
module burst_addr_gen
    import sram_port_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic advance,
    input wire logic [sram_port_pkg::BURST_W-1:0] startLsbs,
    input wire logic linearN,
    output logic [sram_port_pkg::BURST_W-1:0] curLsbs
);
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] count;
    logic [BURST_W-1:0] nextCount;

    // Two-bit count wraps after the loaded address and three more
    assign nextCount = count + COUNT_STEP;

    always_comb begin
        if (load) begin
            curLsbs = startLsbs;
        end else if (linearN) begin
            curLsbs = start ^ nextCount;
        end else begin
            curLsbs = start + nextCount;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start <= BURST_RESET;
            count <= BURST_RESET;
        end else if (load) begin
            start <= startLsbs;
            count <= BURST_RESET;
        end else if (advance) begin
            count <= nextCount;
        end
    end
endmodule

/* File: dv/mem_ctrl_model.sv */
// Controller model: drives commands and the late write data of the SRAM port.
// Assumes the bench calls cycle once per clock and changes straps only while idle.
module mem_ctrl_model (
    input wire logic clk,
    input wire logic flowThroughSelN,
    output logic clkGateN,
    output logic selectOneN,
    output logic selectTwo,
    output logic selectThreeN,
    output logic storeRequestN,
    output logic [7:0] byteLaneWriteN,
    output logic burstStepLoad,
    output logic [18:0] addr,
    output logic [71:0] dataLaneIn
);
    timeunit 1ns;
    timeprecision 100ps;
    int ec = 0;
    logic [71:0] wq [int];
    initial begin
        {clkGateN, selectOneN, selectTwo, selectThreeN, storeRequestN, burstStepLoad} = 6'h1e;
        byteLaneWriteN = 8'hff;
        addr = 19'h0;
        dataLaneIn = 72'h0;
    end
    task automatic cycle(input bit gate, input bit wr, input bit cont, input logic [18:0] a,
                         input logic [7:0] ben, input logic [2:0] off, input logic [71:0] d);
        @(posedge clk);
        #1;
        if (!clkGateN) ec++;
        // Outside its data slot the bus toggles, so stale data never looks valid
        dataLaneIn = wq.exists(ec) ? wq[ec] : ~dataLaneIn;
        clkGateN = gate;
        burstStepLoad = cont;
        {selectThreeN, selectTwo, selectOneN} = off ^ 3'h2;
        storeRequestN = !wr;
        byteLaneWriteN = ben;
        addr = a;
        if (wr && !gate) wq[ec + (flowThroughSelN ? 2 : 1)] = d;
    endtask
endmodule

/* File: dv/sync_burst_sram_port_test.sv */
// Self-checking bench: reference memory and read schedule against the SRAM port.
// Assumes mem_ctrl_model drives all command and write data inputs.
module sync_burst_sram_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sram_port_pkg::*;
    logic clk = 0, sys_rst = 1, outputDriveN = 0, sleepRequest = 0;
    logic flowThroughSelN = 1, linearOrderSelN = 0;
    logic clkGateN, selectOneN, selectTwo, selectThreeN, storeRequestN, burstStepLoad;
    logic dataLaneOe;
    logic [LANES-1:0] byteLaneWriteN;
    logic [ADDR_W-1:0] addr, base, b;
    logic [DATA_W-1:0] dataLaneIn, dataLaneOut;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] rq [int];
    logic ro [int];
    int n_fail = 0, checks_done = 0, lastKind = 0, cnt = 0;
    bit asleep = 0, oeOff = 0;

    sync_burst_sram_port sync_burst_sram_port_i (.clk, .sys_rst, .clkGateN, .selectOneN,
        .selectTwo, .selectThreeN, .storeRequestN, .byteLaneWriteN, .burstStepLoad, .addr,
        .dataLaneIn, .dataLaneOut, .dataLaneOe, .outputDriveN, .sleepRequest,
        .flowThroughSelN, .linearOrderSelN);
    mem_ctrl_model mem_ctrl_model_i (.clk, .flowThroughSelN, .clkGateN, .selectOneN,
        .selectTwo, .selectThreeN, .storeRequestN, .byteLaneWriteN, .burstStepLoad, .addr,
        .dataLaneIn);

    initial forever #2.5 clk = ~clk;

    task automatic chk(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One clock: issue a command, check what is due now, then update the model
    task automatic go(bit gate, int kind, bit cont, logic [ADDR_W-1:0] a, logic [7:0] ben,
                      logic [2:0] off);
        logic [DATA_W-1:0] d;
        logic [1:0] lo;
        int ec;
        d = DATA_W'({$urandom, $urandom, $urandom});
        lo = a[1:0];
        if (cont && !gate) begin
            cnt++;
            lo = linearOrderSelN ? base[1:0] ^ 2'(cnt) : base[1:0] + 2'(cnt);
        end else if (!gate) begin
            base = a;
            cnt = 0;
            lastKind = off == 3'h0 ? kind : 0;
        end
        if (cont) kind = lastKind;
        mem_ctrl_model_i.cycle(gate, kind == 2, cont, cont ? ADDR_W'($urandom) : a, ben, off, d);
        ec = mem_ctrl_model_i.ec;
        chk("oe", DATA_W'(dataLaneOe), DATA_W'(rq.exists(ec) && ro[ec]));
        if (rq.exists(ec) && ro[ec]) chk("read", dataLaneOut, rq[ec]);
        if (gate || asleep || kind == 0 || (!cont && off != 3'h0)) return;
        a = {base[ADDR_W-1:2], lo};
        if (kind == 1) begin
            rq[ec + (flowThroughSelN ? 2 : 1)] = mem[a];
            ro[ec + (flowThroughSelN ? 2 : 1)] = !oeOff;
        end else for (int i = 0; i < LANES; i++)
            if (!ben[i]) mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    endtask

    task automatic idle(int n);
        repeat (n) go(0, 0, 0, ADDR_W'($urandom), 8'hff, 3'h1);
    endtask

    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end

    initial begin
        void'($urandom(40));
        idle(16);
        sys_rst = 0;
        for (int m = 1; m >= 0; m--) begin
            flowThroughSelN = m[0];
            idle(4);
            b = ADDR_W'($urandom) & 19'h7fffc;
            for (int i = 0; i < 4; i++) go(0, 2, 0, b + 19'(i), 8'h00, 3'h0);
            go(0, 2, 0, b, {1'b1, 6'($urandom), 1'b0}, 3'h0);
            go(0, 2, 0, b + 19'h1, 8'hff, 3'h0);
            for (int i = 0; i < 3; i++) go(0, 2, 0, b + 19'h2, 8'h00, 3'(1 << i));
            // A continue after a deselect must stay a deselect
            go(0, 2, 1, 19'h0, 8'h00, 3'h0);
            for (int i = 0; i < 4; i++) begin
                go(0, 1, 0, b + 19'(i), 8'($urandom), 3'h0);
                if (i == 1) go(1, 2, 0, b + 19'h3, 8'h00, 3'h0);
            end
            go(0, 2, 0, b + 19'h3, 8'h00, 3'h0);
            idle(3);
            for (int o = 0; o < 2; o++) begin
                linearOrderSelN = o[0];
                idle(4);
                go(0, 2, 0, (b ^ 19'h40) | 19'(2'($urandom)), 8'h00, 3'h0);
                repeat (4) go(0, 2, 1, 19'h0, 8'h00, 3'h0);
                idle(3);
                go(0, 1, 0, (b ^ 19'h40) | 19'(2'($urandom)), 8'h00, 3'h0);
                for (int i = 0; i < 4; i++) go(i == 2, 1, 1, 19'h0, 8'h00, 3'h0);
                idle(3);
            end
            $display("mode test %0d done, mismatches %0d", m, n_fail);
        end
        outputDriveN = 1;
        oeOff = 1;
        idle(4);
        go(0, 1, 0, b, 8'h00, 3'h0);
        go(0, 1, 0, b + 19'h1, 8'h00, 3'h0);
        idle(3);
        outputDriveN = 0;
        oeOff = 0;
        sleepRequest = 1;
        idle(4);
        asleep = 1;
        go(0, 2, 0, b, 8'h00, 3'h0);
        go(0, 1, 0, b, 8'h00, 3'h0);
        idle(3);
        sleepRequest = 0;
        idle(4);
        asleep = 0;
        go(0, 1, 0, b, 8'h00, 3'h0);
        idle(3);
        $display("drive and sleep test done, mismatches %0d", n_fail);
        wrap_up();
    end
endmodule
